/* File: cosc_audio_host.sv */
// Audio processor end: makes the bit and frame clocks, sends slot words.
// Assumes core_clk at 100 MHz; the codec samples on the bit clock rise.
`timescale 1ns/1ps
module cosc_audio_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Framing setup
    input wire logic [1:0] serial_word_format,
    input wire logic [1:0] serial_slot_mode,
    input wire logic cycles_per_slot,
    // Slot words, latched at each frame start
    input wire logic [7:0][23:0] tx_slot_word,
    output logic frame_start,
    // Link
    cosc_sai_if.host link
);

    localparam int WORD_W = cosc_pkg::WORD_W;
    localparam int BCLK_HALF_CYC = cosc_pkg::BCLK_HALF_CYC;
    logic [3:0] div_reg, div_next;    // Half bit period counter
    logic bclk_reg, bclk_next;        // Bit clock level
    logic lr_reg, lr_next;            // Frame clock level
    logic sd_reg, sd_next;            // Data bit on the line
    logic [4:0] pos_reg, pos_next;    // Bit position within slot
    logic [2:0] slot_reg, slot_next;  // Slot within frame
    logic fs_reg, fs_next;            // Frame start pulse
    logic [7:0][23:0] word_reg, word_next; // Words of current frame

    // Framing advances on each bit clock fall
    always_comb begin
        logic [3:0] nslots;
        logic [5:0] map;
        logic wrap_slot;
        nslots = 4'h0;
        map = 6'h00;
        wrap_slot = 1'b0;
        div_next = div_reg + 4'h1;
        bclk_next = bclk_reg;
        lr_next = lr_reg;
        sd_next = sd_reg;
        pos_next = pos_reg;
        slot_next = slot_reg;
        fs_next = 1'b0;
        word_next = word_reg;
        if (div_reg == 4'(BCLK_HALF_CYC - 1)) begin
            div_next = 4'h0;
            bclk_next = ~bclk_reg;
            if (bclk_reg) begin
                // Falling edge: data and frame clock change here
                nslots = cosc_pkg::fn_slots(serial_slot_mode); // [RULE10]
                wrap_slot = pos_reg >= cosc_pkg::fn_last_pos(cycles_per_slot);
                pos_next = wrap_slot ? 5'h00 : pos_reg + 5'h01; // [RULE13]
                if (wrap_slot) begin
                    if ({1'b0, slot_reg} >= nslots - 4'h1) begin
                        // New frame takes fresh words
                        slot_next = 3'h0;
                        fs_next = 1'b1;
                        word_next = tx_slot_word;
                    end else begin
                        slot_next = slot_reg + 3'h1;
                    end
                end
                lr_next = {1'b0, slot_next} >= (nslots >> 1);
                // Place word bits per format [RULE7] [RULE8] [RULE9]
                map = cosc_pkg::fn_slot_bit(serial_word_format,
                                            cycles_per_slot, pos_next);
                sd_next = map[5] &
                    word_next[slot_next][5'(WORD_W - 1) - map[4:0]];
            end
        end
    end

    // Register the link state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            div_reg <= 4'h0;
            bclk_reg <= 1'b0;
            lr_reg <= 1'b1;
            sd_reg <= 1'b0;
            pos_reg <= 5'h1f;   // First fall opens a frame
            slot_reg <= 3'h7;
            fs_reg <= 1'b0;
            word_reg <= '0;
        end else begin
            div_reg <= div_next;
            bclk_reg <= bclk_next;
            lr_reg <= lr_next;
            sd_reg <= sd_next;
            pos_reg <= pos_next;
            slot_reg <= slot_next;
            fs_reg <= fs_next;
            word_reg <= word_next;
        end
    end

    assign link.bclk = bclk_reg;
    assign link.lrclk = lr_reg;
    assign link.sdata = sd_reg;
    assign frame_start = fs_reg;

endmodule

/* File: cosc_codec_dev.sv */
// Codec end: control registers for bias, converters, pin mutes and the
// serial port, and a receiver for the first two slots of each frame.
// Assumes the link clocks come from the processor, slower than core_clk/4.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Two bias outputs, each enable and level
// RULE2 - Channel 0 attenuation in 0.375 dB steps
// RULE3 - Channel 1 attenuation independent, resets 0 dB
// RULE4 - Right mute field decodes per pin
// RULE5 - Left mute field decodes likewise
// RULE6 - Muted pin becomes common-mode reference
// RULE7 - Format 00: data one bit late
// RULE8 - Format 01: data on frame edge
// RULE9 - Formats 10/11: right justified 24/16
// RULE10 - Mode selects stereo or 2/4/8 slots
// RULE11 - Rate code maps to kHz
// RULE12 - Software should prefer 24-bit words
// RULE13 - Slot is 32 or 16 bit clocks
// RULE14 - Converter invert, silence, enable bits
module cosc_codec_dev (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Serial port setting with no register
    input wire logic cycles_per_slot,
    // Analog side controls
    output logic [9:0] bias_output_0_permille,
    output logic [9:0] bias_output_1_permille,
    output logic [9:0] ch0_atten_eighth_db,
    output logic [9:0] ch1_atten_eighth_db,
    output logic [3:0] pin_common_mode,
    output logic [7:0] sample_rate_khz,
    // Received samples
    output logic [23:0] ch0_sample,
    output logic [23:0] ch1_sample,
    output logic sample_valid,
    // Link
    cosc_sai_if.dev link
);

    localparam int WORD_W = cosc_pkg::WORD_W;
    // Registers, write state
    logic [7:0] bias_supply_control_reg, bias_supply_control_next;
    logic [7:0] output_converter_control_reg, output_converter_control_next;
    logic [7:0] output_volume_ch0_reg, output_volume_ch0_next;
    logic [7:0] output_volume_ch1_reg, output_volume_ch1_next;
    logic [7:0] output_pin_mutes_reg, output_pin_mutes_next;
    logic [7:0] serial_port_format_reg, serial_port_format_next;
    logic [7:0] rdata_reg, rdata_next;   // Read data, one cycle late
    // Decoded analog controls, registered so outputs come from flops
    logic [9:0] bias0_reg, bias0_next;
    logic [9:0] bias1_reg, bias1_next;
    logic [9:0] att0_reg, att0_next;
    logic [9:0] att1_reg, att1_next;
    logic [3:0] cm_reg, cm_next;
    logic [7:0] rate_reg, rate_next;
    // Field views
    logic [1:0] serial_word_format;
    logic [1:0] serial_slot_mode;
    logic [3:0] serial_sample_rate;
    logic [1:0] right_pin_silence;
    logic [1:0] left_pin_silence;
    assign serial_word_format = serial_port_format_reg[cosc_pkg::B_FMT_LO+:2];
    assign serial_slot_mode = serial_port_format_reg[cosc_pkg::B_MODE_LO+:2];
    assign serial_sample_rate = serial_port_format_reg[cosc_pkg::B_RATE_LO+:4];
    assign right_pin_silence = output_pin_mutes_reg[cosc_pkg::B_RIGHT_LO+:2];
    assign left_pin_silence = output_pin_mutes_reg[cosc_pkg::B_LEFT_LO+:2];

    // Register writes and read mux
    always_comb begin
        bias_supply_control_next = bias_supply_control_reg;
        output_converter_control_next = output_converter_control_reg;
        output_volume_ch0_next = output_volume_ch0_reg;
        output_volume_ch1_next = output_volume_ch1_reg;
        output_pin_mutes_next = output_pin_mutes_reg;
        serial_port_format_next = serial_port_format_reg;
        if (reg_write) begin
            case (reg_addr)
                cosc_pkg::OFS_BIAS:
                    bias_supply_control_next = reg_wdata & cosc_pkg::MSK_BIAS;
                cosc_pkg::OFS_CONV:
                    output_converter_control_next =
                        reg_wdata & cosc_pkg::MSK_CONV; // [RULE14]
                cosc_pkg::OFS_VOL0: output_volume_ch0_next = reg_wdata;
                cosc_pkg::OFS_VOL1: output_volume_ch1_next = reg_wdata;
                cosc_pkg::OFS_PINS:
                    output_pin_mutes_next = reg_wdata & cosc_pkg::MSK_PINS;
                cosc_pkg::OFS_SAI: serial_port_format_next = reg_wdata;
                default: ;   // Unmapped writes are dropped
            endcase
        end
        case (reg_addr)
            cosc_pkg::OFS_BIAS: rdata_next = bias_supply_control_reg;
            cosc_pkg::OFS_CONV: rdata_next = output_converter_control_reg;
            cosc_pkg::OFS_VOL0: rdata_next = output_volume_ch0_reg;
            cosc_pkg::OFS_VOL1: rdata_next = output_volume_ch1_reg;
            cosc_pkg::OFS_PINS: rdata_next = output_pin_mutes_reg;
            cosc_pkg::OFS_SAI: rdata_next = serial_port_format_reg;
            default: rdata_next = 8'h00;
        endcase
        // Analog decode from the settled register values
        bias0_next = 10'h000;
        bias1_next = 10'h000;
        if (bias_supply_control_reg[cosc_pkg::B_BIAS0_ON]) begin // [RULE1]
            bias0_next = bias_supply_control_reg[cosc_pkg::B_BIAS0_LVL] ?
                cosc_pkg::BIAS_LOW_PERMILLE : cosc_pkg::BIAS_HIGH_PERMILLE;
        end
        if (bias_supply_control_reg[cosc_pkg::B_BIAS1_ON]) begin // [RULE1]
            bias1_next = bias_supply_control_reg[cosc_pkg::B_BIAS1_LVL] ?
                cosc_pkg::BIAS_LOW_PERMILLE : cosc_pkg::BIAS_HIGH_PERMILLE;
        end
        // Widened before the product, or code 255 would wrap in 8 bits
        att0_next = 10'(output_volume_ch0_reg) *
            10'(cosc_pkg::ATTEN_STEP_EIGHTHS); // [RULE2]
        att1_next = 10'(output_volume_ch1_reg) *
            10'(cosc_pkg::ATTEN_STEP_EIGHTHS); // [RULE3]
        // Low bit silences positive pin, high bit negative
        cm_next = {right_pin_silence, left_pin_silence}; // [RULE4] [RULE5]
        rate_next = cosc_pkg::fn_rate_khz(serial_sample_rate); // [RULE11]
    end

    // Register state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bias_supply_control_reg <= cosc_pkg::RST_BIAS;
            output_converter_control_reg <= cosc_pkg::RST_CONV; // [RULE14]
            output_volume_ch0_reg <= cosc_pkg::RST_VOL0;
            output_volume_ch1_reg <= cosc_pkg::RST_VOL1; // [RULE3]
            output_pin_mutes_reg <= cosc_pkg::RST_PINS; // [RULE4] [RULE5]
            serial_port_format_reg <= cosc_pkg::RST_SAI;
            rdata_reg <= 8'h00;
            bias0_reg <= 10'h000;
            bias1_reg <= 10'h000;
            att0_reg <= 10'h000;
            att1_reg <= 10'h000;
            cm_reg <= 4'hf;
            rate_reg <= 8'h00;
        end else begin
            bias_supply_control_reg <= bias_supply_control_next;
            output_converter_control_reg <= output_converter_control_next;
            output_volume_ch0_reg <= output_volume_ch0_next;
            output_volume_ch1_reg <= output_volume_ch1_next;
            output_pin_mutes_reg <= output_pin_mutes_next;
            serial_port_format_reg <= serial_port_format_next;
            rdata_reg <= rdata_next;
            bias0_reg <= bias0_next;
            bias1_reg <= bias1_next;
            att0_reg <= att0_next; // [RULE2] [RULE3]
            att1_reg <= att1_next;
            cm_reg <= cm_next; // [RULE6]
            rate_reg <= rate_next;
        end
    end

    // Link synchronisers; stage one feeds only stage two
    logic [1:0] bclk_s1, bclk_s2, bclk_s3;
    logic lr_s1, lr_s2, sd_s1, sd_s2;

    // Receiver state
    logic lr_prev_reg, lr_prev_next;    // Frame clock at last rise
    logic [4:0] pos_reg, pos_next;      // Bit position within slot
    logic [2:0] slot_reg, slot_next;    // Slot within frame
    logic [23:0] shift_reg, shift_next; // Word being assembled
    logic [23:0] s0_reg, s0_next;
    logic [23:0] s1_reg, s1_next;
    logic sv_reg, sv_next;
    // Sampling on each bit clock rise
    always_comb begin
        logic [5:0] map;
        logic [23:0] word;
        logic [4:0] last;
        logic [7:0] conv;   // Converter control, short name for the gates
        map = 6'h00;
        conv = output_converter_control_reg;
        word = 24'h000000;
        last = cosc_pkg::fn_last_pos(cycles_per_slot); // [RULE13]
        lr_prev_next = lr_prev_reg;
        pos_next = pos_reg;
        slot_next = slot_reg;
        shift_next = shift_reg;
        s0_next = s0_reg;
        s1_next = s1_reg;
        sv_next = 1'b0;
        if (bclk_s2[0] && !bclk_s3[0]) begin
            lr_prev_next = lr_s2;
            if (lr_prev_reg && !lr_s2) begin
                // Frame clock fall opens slot 0
                pos_next = 5'h00;
                slot_next = 3'h0;
            end else if (pos_reg >= last) begin
                pos_next = 5'h00;
                slot_next = slot_reg + 3'h1;
            end else begin
                pos_next = pos_reg + 5'h01;
            end
            if (pos_next == 5'h00) begin
                shift_next = 24'h000000;
            end
            // Bit placement per format [RULE7] [RULE8] [RULE9]
            map = cosc_pkg::fn_slot_bit(serial_word_format, cycles_per_slot,
                                        pos_next);
            if (map[5]) begin
                shift_next[5'(WORD_W - 1) - map[4:0]] = sd_s2;
            end
            // Slot close: only the first two slots feed converters
            if (pos_next == last && {1'b0, slot_next} <
                    cosc_pkg::fn_slots(serial_slot_mode)) begin // [RULE10]
                word = shift_next;
                if (conv[cosc_pkg::B_CONV_INV]) begin
                    word = 24'h000000 - word; // [RULE14]
                end
                if (slot_next == 3'h0) begin
                    s0_next = (conv[cosc_pkg::B_CONV0_ON] && // [RULE14]
                        !conv[cosc_pkg::B_CONV0_SIL]) ? word : 24'h000000;
                end
                if (slot_next == 3'h1) begin
                    s1_next = (conv[cosc_pkg::B_CONV1_ON] && // [RULE14]
                        !conv[cosc_pkg::B_CONV1_SIL]) ? word : 24'h000000;
                    sv_next = 1'b1;
                end
            end
        end
    end

    // Receiver registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lr_prev_reg <= 1'b1;
            pos_reg <= 5'h00;
            slot_reg <= 3'h7;
            shift_reg <= 24'h000000;
            s0_reg <= 24'h000000;
            s1_reg <= 24'h000000;
            sv_reg <= 1'b0;
            bclk_s1 <= 2'h0;
            bclk_s2 <= 2'h0;
            bclk_s3 <= 2'h0;
            lr_s1 <= 1'b1;
            lr_s2 <= 1'b1;
            sd_s1 <= 1'b0;
            sd_s2 <= 1'b0;
        end else begin
            lr_prev_reg <= lr_prev_next;
            pos_reg <= pos_next;
            slot_reg <= slot_next;
            shift_reg <= shift_next;
            s0_reg <= s0_next;
            s1_reg <= s1_next;
            sv_reg <= sv_next;
            bclk_s1 <= {1'b0, link.bclk};
            bclk_s2 <= bclk_s1;
            bclk_s3 <= bclk_s2;
            lr_s1 <= link.lrclk;
            lr_s2 <= lr_s1;
            sd_s1 <= link.sdata;
            sd_s2 <= sd_s1;
        end
    end

    assign reg_rdata = rdata_reg;
    assign bias_output_0_permille = bias0_reg;
    assign bias_output_1_permille = bias1_reg;
    assign ch0_atten_eighth_db = att0_reg;
    assign ch1_atten_eighth_db = att1_reg;
    assign pin_common_mode = cm_reg;
    assign sample_rate_khz = rate_reg;
    assign ch0_sample = s0_reg;
    assign ch1_sample = s1_reg;
    assign sample_valid = sv_reg;
endmodule

/* File: cosc_link_props.sv */
// Checker for the serial link joining the processor and codec ends.
// Assumes it sits beside the link interface, all in the core_clk domain.
`timescale 1ns/1ps
module cosc_link_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Link lines
    input wire logic bclk,
    input wire logic lrclk,
    input wire logic sdata,
    // Frame mark from the processor end
    input wire logic frame_start
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Bit clock holds each level for six core cycles
    sequence s_high_half;
        bclk [*6] ##1 !bclk;
    endsequence
    sequence s_low_half;
        !bclk [*6] ##1 bclk;
    endsequence

    a_bclk_high_half: assert property ($rose(bclk) |-> s_high_half)
        else $error("bit clock high phase has wrong length");
    a_bclk_low_half: assert property ($fell(bclk) |-> s_low_half)
        else $error("bit clock low phase has wrong length");
    // Framing and data only move on the bit clock fall, so the far end
    // always samples settled lines on the rise
    a_frame_on_fall: assert property
        ($changed(lrclk) |-> $fell(bclk))
        else $error("frame clock moved away from a bit clock fall");
    a_data_on_fall: assert property
        ($changed(sdata) |-> $fell(bclk))
        else $error("serial data moved away from a bit clock fall");
    // Shortest half frame is sixteen bit clocks, far above eight cycles
    a_frame_low_hold: assert property
        ($fell(lrclk) |-> !lrclk [*8])
        else $error("frame clock low phase too short");
    // A new frame always opens on a bit clock fall with the frame clock low
    a_start_mark_low: assert property
        (frame_start |-> $fell(bclk) && !lrclk)
        else $error("frame start mark not on a low frame clock fall");
    // Idle levels while held in reset
    a_reset_idle_lines: assert property (disable iff (1'b0)
        !reset_n |=> !bclk && lrclk && !sdata)
        else $error("link lines not idle in reset");
endmodule

/* File: cosc_pkg.sv */
// Package for the output converter, bias and serial port control block.
// Assumes both link ends and the testbench use these names directly.
package cosc_pkg;

    // Register offsets
    localparam logic [7:0] OFS_BIAS = 8'h2d;
    localparam logic [7:0] OFS_CONV = 8'h2e;
    localparam logic [7:0] OFS_VOL0 = 8'h2f;
    localparam logic [7:0] OFS_VOL1 = 8'h30;
    localparam logic [7:0] OFS_PINS = 8'h31;
    localparam logic [7:0] OFS_SAI = 8'h32;

    // Reset values
    localparam logic [7:0] RST_BIAS = 8'h00;
    localparam logic [7:0] RST_CONV = 8'h18;
    localparam logic [7:0] RST_VOL0 = 8'h00;
    localparam logic [7:0] RST_VOL1 = 8'h00;
    localparam logic [7:0] RST_PINS = 8'h0f;
    localparam logic [7:0] RST_SAI = 8'h00;

    // Writable bits; the rest are reserved and read zero
    localparam logic [7:0] MSK_BIAS = 8'h33;
    localparam logic [7:0] MSK_CONV = 8'h3b;
    localparam logic [7:0] MSK_PINS = 8'h0f;

    // Field positions
    localparam int B_BIAS1_ON = 5;
    localparam int B_BIAS0_ON = 4;
    localparam int B_BIAS1_LVL = 1;
    localparam int B_BIAS0_LVL = 0;
    localparam int B_CONV_INV = 5;
    localparam int B_CONV1_SIL = 4;
    localparam int B_CONV0_SIL = 3;
    localparam int B_CONV1_ON = 1;
    localparam int B_CONV0_ON = 0;
    localparam int B_RIGHT_LO = 2;
    localparam int B_LEFT_LO = 0;
    localparam int B_FMT_LO = 6;
    localparam int B_MODE_LO = 4;
    localparam int B_RATE_LO = 0;

    // Bias levels in thousandths of the analog supply
    localparam logic [9:0] BIAS_HIGH_PERMILLE = 10'h384;
    localparam logic [9:0] BIAS_LOW_PERMILLE = 10'h28a;

    // Attenuation step, eighths of a dB per code
    localparam logic [1:0] ATTEN_STEP_EIGHTHS = 2'h3;

    // Serial word formats
    localparam logic [1:0] FMT_DELAYED = 2'h0;
    localparam logic [1:0] FMT_ALIGNED = 2'h1;
    localparam logic [1:0] FMT_RJ24 = 2'h2;
    localparam logic [1:0] FMT_RJ16 = 2'h3;

    // Word length held on the link, MSB first
    localparam int WORD_W = 24;

    // Bit clock made by the host from the core clock
    localparam int CORE_PERIOD_NS = 10;
    localparam int BCLK_PERIOD_NS = 120;
    localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / CORE_PERIOD_NS / 2;

    // Slots per frame for a slot mode
    function automatic logic [3:0] fn_slots(input logic [1:0] mode);
        case (mode)
            2'h2: fn_slots = 4'h4;
            2'h3: fn_slots = 4'h8;
            default: fn_slots = 4'h2;
        endcase
    endfunction

    // Last bit position in a slot
    function automatic logic [4:0] fn_last_pos(input logic cps16);
        fn_last_pos = cps16 ? 5'h0f : 5'h1f;
    endfunction

    // Maps a slot position to {valid, word bit counted from MSB}
    function automatic logic [5:0] fn_slot_bit(input logic [1:0] fmt,
                                               input logic cps16,
                                               input logic [4:0] pos);
        logic [4:0] off;
        logic [4:0] wlen;
        logic [4:0] idx;
        off = 5'h00;
        wlen = (fmt == FMT_RJ16) ? 5'h10 : 5'h18;
        case (fmt)
            FMT_DELAYED: off = 5'h01;
            FMT_ALIGNED: off = 5'h00;
            FMT_RJ24: off = cps16 ? 5'h00 : 5'h08;
            FMT_RJ16: off = cps16 ? 5'h00 : 5'h10;
            default: off = 5'h00;
        endcase
        idx = pos - off;
        fn_slot_bit = {(pos >= off) && (idx < wlen), idx};
    endfunction

    // Sample rate code to kHz; unlisted codes give zero
    function automatic logic [7:0] fn_rate_khz(input logic [3:0] code);
        case (code)
            4'h0: fn_rate_khz = 8'h30;
            4'h1: fn_rate_khz = 8'h08;
            4'h2: fn_rate_khz = 8'h0c;
            4'h3: fn_rate_khz = 8'h10;
            4'h4: fn_rate_khz = 8'h18;
            4'h5: fn_rate_khz = 8'h20;
            4'h6: fn_rate_khz = 8'h60;
            4'h7: fn_rate_khz = 8'hc0;
            default: fn_rate_khz = 8'h00;
        endcase
    endfunction

endpackage

/* File: cosc_sai_if.sv */
// Serial audio link between the audio processor and the codec.
// Assumes the processor end makes both clocks; all lines are one-way.
`timescale 1ns/1ps
interface cosc_sai_if;
    logic bclk;   // Bit clock, made by the processor
    logic lrclk;  // Frame clock, low for the first half of a frame
    logic sdata;  // Serial data, processor to codec

    modport host (output bclk, output lrclk, output sdata);
    modport dev (input bclk, input lrclk, input sdata);
endinterface

/* File: tb.sv */
// Bench joining the processor and codec ends over one link.
// Assumes the package constants and the register port timing of the ends.
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, reset_n = 0, reg_write = 0, cps = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rate_khz;
    logic [1:0] fmt = 2'h0, mode = 2'h0;
    logic [7:0][23:0] tx;
    logic [9:0] b0, b1, a0, a1;
    logic [3:0] pins;
    logic [23:0] s0, s1;
    logic valid, fstart;
    int err_total = 0, check_count = 0;
    cosc_sai_if cosc_sai_if_inst ();
    cosc_audio_host cosc_audio_host_inst (.core_clk(core_clk),
        .reset_n(reset_n), .serial_word_format(fmt),
        .serial_slot_mode(mode), .cycles_per_slot(cps), .tx_slot_word(tx),
        .frame_start(fstart), .link(cosc_sai_if_inst.host));
    cosc_codec_dev cosc_codec_dev_inst (.core_clk(core_clk),
        .reset_n(reset_n), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cycles_per_slot(cps),
        .bias_output_0_permille(b0), .bias_output_1_permille(b1),
        .ch0_atten_eighth_db(a0), .ch1_atten_eighth_db(a1),
        .pin_common_mode(pins), .sample_rate_khz(rate_khz),
        .ch0_sample(s0), .ch1_sample(s1), .sample_valid(valid),
        .link(cosc_sai_if_inst.dev));
    cosc_link_props cosc_link_props_inst (.core_clk(core_clk),
        .reset_n(reset_n), .bclk(cosc_sai_if_inst.bclk),
        .lrclk(cosc_sai_if_inst.lrclk), .sdata(cosc_sai_if_inst.sdata),
        .frame_start(fstart));
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    // Compare and count
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h, expected %h", $time,
                seen, exp);
        end
    endtask
    // One write, then one edge so decoded outputs have settled
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_write = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1 reg_write = 0;
        @(posedge core_clk);
        #1;
    endtask
    // Read and compare; data arrives one cycle after the address
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1 reg_addr = a;
        @(posedge core_clk);
        #1 chk(24'(reg_rdata), 24'(exp));
    endtask
    // Reset values, an unmapped place and the converter reserved-bit mask
    task t_regs;
        logic [7:0] rv [6] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h0f, 8'h00};
        for (int i = 0; i < 6; i++) rdc(8'h2d + 8'(i), rv[i]);
        chk(24'(pins), 24'hf);
        wr(8'h33, 8'hff);
        rdc(8'h33, 8'h00);
        wr(cosc_pkg::OFS_CONV, 8'hff);
        rdc(cosc_pkg::OFS_CONV, 8'h3b);
    endtask
    // Bias enables and levels
    task t_bias;
        wr(cosc_pkg::OFS_BIAS, 8'hff);
        rdc(cosc_pkg::OFS_BIAS, 8'h33);
        chk(24'({b1, b0}), 24'({10'h28a, 10'h28a}));
        wr(cosc_pkg::OFS_BIAS, 8'h10);
        chk(24'({b1, b0}), 24'({10'h000, 10'h384}));
        wr(cosc_pkg::OFS_BIAS, 8'h21);
        chk(24'({b1, b0}), 24'({10'h384, 10'h000}));
    endtask
    // Volumes: full scale code and the smallest step, kept apart
    task t_volume;
        wr(cosc_pkg::OFS_VOL0, 8'hff);
        chk(24'({a1, a0}), 24'({10'h000, 10'h2fd}));
        wr(cosc_pkg::OFS_VOL1, 8'h01);
        chk(24'({a1, a0}), 24'({10'h003, 10'h2fd}));
    endtask
    // Every pin silence code, right and left set differently
    task t_mutes;
        for (int c = 0; c < 4; c++) begin
            wr(cosc_pkg::OFS_PINS, {4'h0, 2'(c), ~2'(c)});
            chk(24'(pins), 24'({2'(c), ~2'(c)}));
        end
    endtask
    // Every listed sample rate code
    task t_rate;
        logic [7:0] rt [8] = '{8'h30, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20,
            8'h60, 8'hc0};
        for (int i = 0; i < 8; i++) begin
            wr(cosc_pkg::OFS_SAI, {4'h0, 4'(i)});
            chk(24'(rate_khz), 24'(rt[i]));
        end
        // First unlisted code decodes to zero
        wr(cosc_pkg::OFS_SAI, 8'h08);
        chk(24'(rate_khz), 24'h0);
    endtask
    // Frames: the first after a change may be mixed, so judge the second
    task t_link(input logic [1:0] f, input logic [1:0] m, input logic c,
                input logic [7:0] cv, input logic [23:0] e0,
                input logic [23:0] e1);
        int n;
        n = 0;
        fmt = f;
        mode = m;
        cps = c;
        wr(cosc_pkg::OFS_CONV, cv);
        wr(cosc_pkg::OFS_SAI, {f, m, 4'h0});
        repeat (2) do begin
            @(posedge core_clk);
            #1 n++;
        end while (valid !== 1'b1 && n < 20000);
        chk(24'(n >= 20000), 24'h0);
        chk(s0, e0);
        chk(s1, e1);
    endtask
    // Verdict in one place
    task give_verdict;
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog: at most about 16,500 cycles expected, stop at 60,000
    initial begin
        #600000;
        err_total++;
        give_verdict();
    end
    // Main sequence
    initial begin
        for (int i = 0; i < 8; i++) tx[i] = 24'h123400 + 24'(i);
        tx[0] = 24'h5a3c00;
        tx[1] = 24'h81f000;
        repeat (10) @(posedge core_clk);
        #1 reset_n = 1;
        t_regs();
        t_bias();
        t_volume();
        t_mutes();
        t_rate();
        t_link(2'h0, 2'h0, 1'b0, 8'h03, tx[0], tx[1]);
        t_link(2'h1, 2'h1, 1'b0, 8'h03, tx[0], tx[1]);
        t_link(2'h2, 2'h2, 1'b0, 8'h03, tx[0], tx[1]);
        t_link(2'h3, 2'h3, 1'b0, 8'h03, tx[0], tx[1]);
        t_link(2'h1, 2'h0, 1'b1, 8'h03, tx[0], tx[1]);
        t_link(2'h0, 2'h0, 1'b0, 8'h23, -tx[0], -tx[1]);
        t_link(2'h0, 2'h0, 1'b0, 8'h09, 24'h0, 24'h0);
        give_verdict();
    end
endmodule
